// ===== adcc_ctrl.sv
// Controller end: AXI4-Lite registers driving converter instructions
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcc_ctrl #(
  parameter int ADDR_W = 5
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic int_ack_i,
  output logic irq_o,
  output logic [3:0] port_latch_o,
  adcc_if.ctl link
);
  import adcc_pkg::*;
  `include "adcc_regs.svh"

  adcc_cstate_type state_reg;
  adcc_op_type op_reg;
  logic [3:0] a_reg;
  logic [3:0] b_reg;
  logic [3:0] sel_reg;
  logic [3:0] intsel_reg;
  logic [3:0] port_reg;
  logic [9:0] res_reg;
  logic [3:0] rsp_a_reg;
  logic [3:0] rsp_b_reg;
  logic skip_reg;
  logic refused_reg;
  logic mode_reg;
  logic macro_reg;
  logic pend_reg;
  logic wr_go;
  logic cmd_go;
  logic switch;
  logic hold;
  logic [ADDR_W-1:0] waddr;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together once both are offered
  assign wr_go = s_awready_o && s_awvalid_i;
  assign waddr = s_awaddr_i;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= `ADCC_RESP_OK;
    end else begin
      s_awready_o <= s_awvalid_i && s_wvalid_i && !s_awready_o &&
                     !s_bvalid_o;
      s_wready_o <= s_awvalid_i && s_wvalid_i && !s_awready_o &&
                    !s_bvalid_o;
      if (wr_go) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o <= waddr > `ADCC_PORT_OFS || waddr[1:0] != 2'b00 ?
                     `ADCC_RESP_ERR : `ADCC_RESP_OK;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // Read data is captured at the address handshake
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0;
      s_rresp_o <= `ADCC_RESP_OK;
    end else begin
      s_arready_o <= s_arvalid_i && !s_arready_o && !s_rvalid_o;
      if (s_arready_o && s_arvalid_i) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o <= `ADCC_RESP_OK;
        case (s_araddr_i)
          `ADCC_CMD_OFS: s_rdata_o <= {20'h0, b_reg, a_reg, op_reg};
          `ADCC_STAT_OFS: s_rdata_o <= {19'h0, refused_reg,
              state_reg != CS_IDLE, link.busy, link.flag, skip_reg,
              rsp_b_reg, rsp_a_reg};
          `ADCC_RES_OFS: s_rdata_o <= {22'h0, res_reg};
          `ADCC_INTSEL_OFS: s_rdata_o <= {28'h0, intsel_reg};
          `ADCC_PORT_OFS: s_rdata_o <= {28'h0, port_reg};
          default: begin
            s_rdata_o <= 32'h0;
            s_rresp_o <= `ADCC_RESP_ERR;
          end
        endcase
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  assign cmd_go = wr_go && waddr == `ADCC_CMD_OFS && s_wstrb_i[0] &&
                  state_reg == CS_IDLE;
  // Mode change requested by the pending control write
  assign switch = a_reg[`ADCC_MODE_BIT] != mode_reg;
  // cleared interrupt select reaches the device before the write
  // a refused mode change is put back before the write goes out
  assign hold = state_reg == CS_SEL &&
                (switch && link.busy ||
                 mode_reg && !a_reg[`ADCC_MODE_BIT] && link.int_en);

  // Each step issues one instruction and waits for its answer; the poll step reissues its skip until one is taken
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= CS_IDLE;
      pend_reg <= 1'b0;
      link.instr_valid <= 1'b0;
      link.instr_op <= OP_NOP;
      link.acc_a <= 4'h0;
      link.acc_b <= 4'h0;
    end else begin
      link.instr_valid <= 1'b0;
      if (state_reg != CS_IDLE && !pend_reg && !hold) begin
        pend_reg <= 1'b1;
        link.instr_valid <= 1'b1;
        link.acc_a <= a_reg;
        link.acc_b <= b_reg;
        case (state_reg)
          CS_ONE: link.instr_op <= op_reg;
          CS_SEL: link.instr_op <= OP_WR_CTRL;
          CS_START: link.instr_op <= OP_START;
          CS_CLR, CS_POLL: link.instr_op <= OP_SKIP;
          CS_LOW: link.instr_op <= OP_MOVE_LOW;
          default: link.instr_op <= OP_MOVE_HIGH;
        endcase
      end
      if (link.rsp_valid) begin
        pend_reg <= 1'b0;
      end
      case (state_reg)
        CS_IDLE: begin
          if (cmd_go) begin
            // convert macro starts with input select
            state_reg <= s_wdata_i[3:0] == OP_CONVERT ? CS_SEL :
                         s_wdata_i[3:0] == OP_WR_CTRL ? CS_SEL : CS_ONE;
          end
        end
        CS_SEL: begin
          // skip right after a mode change
          if (link.rsp_valid) begin
            state_reg <= switch ? CS_CLR : macro_reg ? CS_START : CS_IDLE;
          end
        end
        CS_CLR: begin
          if (link.rsp_valid) begin
            state_reg <= macro_reg ? CS_START : CS_IDLE;
          end
        end
        CS_START: begin
          if (link.rsp_valid) begin
            state_reg <= CS_POLL;
          end
        end
        CS_POLL: begin
          // read only after a taken skip
          if (link.rsp_valid && link.skip) begin
            state_reg <= CS_LOW;
          end
        end
        CS_LOW: begin
          if (link.rsp_valid) begin
            state_reg <= CS_HIGH;
          end
        end
        CS_HIGH, CS_ONE: begin
          if (link.rsp_valid) begin
            state_reg <= CS_IDLE;
          end
        end
        default: begin
          state_reg <= CS_IDLE;
        end
      endcase
    end
  end

  // Command fields; the macro forces conversion mode on its input
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_reg <= OP_NOP;
      a_reg <= 4'h0;
      b_reg <= 4'h0;
      macro_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else if (cmd_go) begin
      op_reg <= adcc_op_type'(s_wdata_i[3:0]);
      macro_reg <= s_wdata_i[3:0] == OP_CONVERT;
      a_reg <= s_wdata_i[3:0] == OP_CONVERT ?
               {2'b00, s_wdata_i[5:4]} : s_wdata_i[7:4];
      b_reg <= s_wdata_i[11:8];
      refused_reg <= 1'b0;
    end else if (state_reg == CS_SEL && !pend_reg && switch &&
                 link.busy) begin
      a_reg[`ADCC_MODE_BIT] <= mode_reg;
      refused_reg <= 1'b1;
    end
  end

  // Shadow of the mode bit, answers and result
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg <= 1'b0;
      res_reg <= 10'h000;
      rsp_a_reg <= 4'h0;
      rsp_b_reg <= 4'h0;
      skip_reg <= 1'b0;
    end else if (link.rsp_valid) begin
      rsp_a_reg <= link.rsp_a;
      rsp_b_reg <= link.rsp_b;
      skip_reg <= link.skip;
      if (state_reg == CS_SEL) begin
        mode_reg <= a_reg[`ADCC_MODE_BIT];
      end
      if (state_reg == CS_LOW) begin
        res_reg[1:0] <= link.rsp_a[3:2];
      end
      if (state_reg == CS_HIGH) begin
        res_reg[9:2] <= {link.rsp_b, link.rsp_a};
      end
    end
  end

  // Interrupt select and port latch registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intsel_reg <= 4'h0;
      port_reg <= `ADCC_PORT_RST;
    end else begin
      if (wr_go && waddr == `ADCC_INTSEL_OFS && s_wstrb_i[0]) begin
        intsel_reg <= s_wdata_i[3:0];
      end
      if (wr_go && waddr == `ADCC_PORT_OFS && s_wstrb_i[0]) begin
        port_reg <= s_wdata_i[3:0];
      end
      // drop interrupt select before leaving comparator
      if (state_reg == CS_SEL && !pend_reg && mode_reg &&
          !a_reg[`ADCC_MODE_BIT]) begin
        intsel_reg[`ADCC_INT_BIT] <= 1'b0;
      end
    end
  end

  // the selected analog pin holds its port latch at 1
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_latch_o <= `ADCC_PORT_RST;
      irq_o <= 1'b0;
      link.int_en <= 1'b0;
      link.int_taken <= 1'b0;
    end else begin
      port_latch_o <= port_reg | (4'h1 << sel_reg[1:0]);
      irq_o <= link.irq;
      link.int_en <= intsel_reg[`ADCC_INT_BIT];
      link.int_taken <= int_ack_i;
    end
  end

  // Input currently selected on the device
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_reg <= 4'h0;
    end else if (state_reg == CS_SEL && link.rsp_valid) begin
      sel_reg <= a_reg;
    end
  end
endmodule

// ===== adcc_device.sv
// Converter device end: control register, SAR sequencer, comparator, flag
`timescale 1ns/1ps
module adcc_device #(
  parameter int MC_DIV = 1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  adcc_if.dev link,
  output logic [9:0] dac_code_o,
  output logic dac_on_o,
  output logic [3:0] ain_sel_o,
  input wire logic vref_below_vin_i
);
  import adcc_pkg::*;
  `include "adcc_regs.svh"

  // One-hot pin select from the two select bits
  function automatic logic [3:0] onehot4(input logic [1:0] sel);
    onehot4 = 4'h1 << sel;
  endfunction
  logic [3:0] ctrl_reg;
  logic [7:0] cmp_reg;
  logic [9:0] sar_reg;
  logic [9:0] result_reg;
  logic [5:0] mc_cnt_reg;
  logic [2:0] trial_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [7:0] div_reg;
  logic flag_reg;
  adcc_dstate_type state_reg;
  logic mode;
  logic instr_wr;
  logic to_conv;
  logic mc_tick;
  logic conv_done;
  logic cmp_done;
  logic cmp_below;
  logic skip_hit;
  logic flag_set;
  logic flag_clr;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // mode from control bit
  assign mode = ctrl_reg[`ADCC_MODE_BIT];
  assign instr_wr = link.instr_valid && link.instr_op == OP_WR_CTRL;
  assign to_conv = instr_wr && mode && !link.acc_a[`ADCC_MODE_BIT];
  assign skip_hit = link.instr_valid && link.instr_op == OP_SKIP &&
                    flag_reg;
  // all four bits stored, bit 2 spare
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `ADCC_CTRL_RST;
    end else if (instr_wr) begin
      ctrl_reg <= link.acc_a;
    end
  end
  // B to high nibble, A to low nibble
  // separate storage, never touched by mode changes
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmp_reg <= 8'h00;
    end else if (link.instr_valid && link.instr_op == OP_LOAD_CMP &&
                 mode) begin
      cmp_reg <= {link.acc_b, link.acc_a};
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle timebase
  // ----------------------------------------------------------------
  // Free running so the count stays aligned to the core's machine cycle
  assign mc_tick = div_reg == 8'(MC_DIV - 1);
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg <= 8'h00;
    end else if (mc_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // end of conversion window
  assign conv_done = state_reg == DS_CONV && mc_tick &&
                     mc_cnt_reg == `ADCC_CONV_MC - 6'd1;
  assign cmp_done = state_reg == DS_CMP && mc_tick &&
                    mc_cnt_reg == `ADCC_CMP_MC - 6'd1;
  assign cmp_below = !vref_below_vin_i;
  // A start while busy is ignored; the running operation finishes
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= DS_IDLE;
      mc_cnt_reg <= 6'd0;
    end else begin
      case (state_reg)
        DS_IDLE: begin
          if (link.instr_valid && link.instr_op == OP_START) begin
            state_reg <= mode ? DS_CMP : DS_CONV;
            mc_cnt_reg <= 6'd0;
          end
        end
        DS_CONV, DS_CMP: begin
          if (conv_done || cmp_done) begin
            state_reg <= DS_IDLE;
          end else if (mc_tick) begin
            mc_cnt_reg <= mc_cnt_reg + 6'd1;
          end
        end
        default: begin
          state_reg <= DS_IDLE;
        end
      endcase
    end
  end
  // clear, then trial from the top bit down
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sar_reg <= `ADCC_SAR_CLR;
      bit_idx_reg <= `ADCC_NO_IDX;
      trial_cnt_reg <= 3'd0;
    end else if (state_reg == DS_IDLE && link.instr_valid &&
                 link.instr_op == OP_START && !mode) begin
      sar_reg <= `ADCC_SAR_TOP;
      bit_idx_reg <= `ADCC_TOP_IDX;
      trial_cnt_reg <= 3'd0;
    end else if (state_reg == DS_CONV && mc_tick &&
                 bit_idx_reg <= `ADCC_TOP_IDX) begin
      if (trial_cnt_reg == `ADCC_TRIAL_MC - 3'd1) begin
        trial_cnt_reg <= 3'd0;
        sar_reg[bit_idx_reg] <= vref_below_vin_i;
        if (bit_idx_reg != 4'h0) begin
          sar_reg[bit_idx_reg - 4'h1] <= 1'b1;
        end
        bit_idx_reg <= bit_idx_reg - 4'h1;
      end else begin
        trial_cnt_reg <= trial_cnt_reg + 3'd1;
      end
    end
  end
  // comparator mode never refreshes it, so treat it as stale
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_reg <= `ADCC_SAR_CLR;
    end else if (conv_done) begin
      result_reg <= sar_reg;
    end
  end

  // ----------------------------------------------------------------
  // Completion / compare flag
  // ----------------------------------------------------------------
  // set on conversion end
  // set on switch to conversion mode
  assign flag_set = conv_done || (cmp_done && cmp_below) || to_conv;
  // interrupt taken or skip actually taken
  assign flag_clr = skip_hit || link.int_taken;
  // Set wins over clear so a completion is never lost
  // a failed comparison leaves the flag at 0
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (cmp_done || flag_clr) begin
      flag_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.irq <= 1'b0;
      link.flag <= 1'b0;
      link.busy <= 1'b0;
    end else begin
      link.irq <= flag_set ? link.int_en : flag_reg && link.int_en &&
                  !flag_clr && !cmp_done;
      link.flag <= flag_set || (flag_reg && !flag_clr && !cmp_done);
      link.busy <= state_reg != DS_IDLE && !conv_done && !cmp_done ||
                   (state_reg == DS_IDLE && link.instr_valid &&
                    link.instr_op == OP_START);
    end
  end

  // ----------------------------------------------------------------
  // Instruction answers, one cycle after the instruction
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link.rsp_valid <= 1'b0;
      link.rsp_a <= 4'h0;
      link.rsp_b <= 4'h0;
      link.skip <= 1'b0;
    end else begin
      link.rsp_valid <= link.instr_valid;
      link.skip <= skip_hit;
      link.rsp_a <= link.acc_a;
      link.rsp_b <= link.acc_b;
      if (link.instr_valid) begin
        case (link.instr_op)
          OP_RD_CTRL: link.rsp_a <= ctrl_reg;
          // comparator read only in comparator mode
          OP_RD_CMP: begin
            if (mode) begin
              link.rsp_b <= cmp_reg[7:4];
              link.rsp_a <= cmp_reg[3:0];
            end
          end
          // low bits to A top, A bottom cleared
          OP_MOVE_LOW: link.rsp_a <= {result_reg[1:0], 2'b00};
          // top nibble to B, next nibble to A
          OP_MOVE_HIGH: begin
            link.rsp_b <= result_reg[9:6];
            link.rsp_a <= result_reg[5:2];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog front end drive
  // ----------------------------------------------------------------
  // 8-bit code on the 10-bit DAC scales by 4
  // select only routes the pin; the controller holds its port latch at 1
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dac_code_o <= `ADCC_SAR_CLR;
      dac_on_o <= 1'b0;
      ain_sel_o <= 4'h0;
    end else begin
      dac_code_o <= mode ? {cmp_reg, 2'b00} : sar_reg;
      dac_on_o <= state_reg != DS_IDLE;
      ain_sel_o <= onehot4(ctrl_reg[1:0]);
    end
  end
endmodule

// ===== adcc_if.sv
// Instruction link between the controller and the converter device
`timescale 1ns/1ps
interface adcc_if;
  adcc_pkg::adcc_op_type instr_op;
  logic instr_valid;
  logic [3:0] acc_a;
  logic [3:0] acc_b;
  logic int_en;
  logic int_taken;
  logic rsp_valid;
  logic [3:0] rsp_a;
  logic [3:0] rsp_b;
  logic skip;
  logic flag;
  logic irq;
  logic busy;
  modport dev (
    input instr_op, instr_valid, acc_a, acc_b, int_en, int_taken,
    output rsp_valid, rsp_a, rsp_b, skip, flag, irq, busy
  );
  modport ctl (
    output instr_op, instr_valid, acc_a, acc_b, int_en, int_taken,
    input rsp_valid, rsp_a, rsp_b, skip, flag, irq, busy
  );
endinterface

// ===== adcc_pkg.sv
// Types shared by both ends of the converter link
package adcc_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_WR_CTRL = 4'h1,
    OP_RD_CTRL = 4'h2,
    OP_START = 4'h3,
    OP_LOAD_CMP = 4'h4,
    OP_RD_CMP = 4'h5,
    OP_MOVE_LOW = 4'h6,
    OP_MOVE_HIGH = 4'h7,
    OP_SKIP = 4'h8,
    OP_CONVERT = 4'hF
  } adcc_op_type;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_CONV = 2'b01,
    DS_CMP = 2'b10
  } adcc_dstate_type;
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_SEL = 3'b001,
    CS_START = 3'b011,
    CS_POLL = 3'b010,
    CS_LOW = 3'b110,
    CS_HIGH = 3'b111,
    CS_CLR = 3'b101,
    CS_ONE = 3'b100
  } adcc_cstate_type;
endpackage

// ===== adcc_properties.sv
// Assertions on the instruction link between controller and device
`timescale 1ns/1ps
module adcc_properties (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire adcc_pkg::adcc_op_type instr_op,
  input wire logic instr_valid,
  input wire logic [3:0] acc_a,
  input wire logic [3:0] acc_b,
  input wire logic int_en,
  input wire logic int_taken,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_a,
  input wire logic [3:0] rsp_b,
  input wire logic skip,
  input wire logic flag,
  input wire logic busy
);
  import adcc_pkg::*;
  logic mode_reg;
  wire go = instr_valid && instr_op == OP_START && !busy && !flag;
  wire wr = instr_valid && instr_op == OP_WR_CTRL;
  wire leave = wr && mode_reg && !acc_a[3];
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Mirror of the mode bit, so checks know which mode a start runs in
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      mode_reg <= 1'b0;
    else if (wr)
      mode_reg <= acc_a[3];
  end
  // Run lengths are pinned at both ends, so an early stop also fails
  conv_len_a: assert property (
    go && !mode_reg |-> ##2 busy ##59 busy ##[1:4] (flag && !busy))
    else $error("conversion length wrong");
  cmp_len_a: assert property (
    go && mode_reg |-> ##2 busy ##5 busy ##[1:4] !busy)
    else $error("comparison length wrong");
  skip_src_a: assert property (
    skip |-> $past(instr_valid) && $past(instr_op) == OP_SKIP)
    else $error("skip without skip instruction");
  skip_clr_a: assert property (skip |-> ##[1:2] !flag)
    else $error("flag kept after skip");
  ack_clr_a: assert property (int_taken |-> ##[1:3] !flag)
    else $error("flag kept after interrupt");
  low_res_a: assert property (
    instr_valid && instr_op == OP_MOVE_LOW |=> rsp_valid && rsp_a[1:0] == 0)
    else $error("low result bits not cleared");
  cmp_gate_a: assert property (
    instr_valid && instr_op == OP_RD_CMP && !mode_reg |=>
    rsp_a == $past(acc_a) && rsp_b == $past(acc_b))
    else $error("comparator read in conversion mode");
  exit_skip_a: assert property (
    leave |-> ##[1:8] (instr_valid && instr_op == OP_SKIP))
    else $error("no skip after leaving comparator");
  exit_int_a: assert property (leave |-> !int_en)
    else $error("interrupt select kept on mode exit");
endmodule

// ===== adcc_regs.svh
// Constants for the converter control block and its controller
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
// Device side
`define ADCC_CTRL_RST 4'h0
`define ADCC_MODE_BIT 3
`define ADCC_CONV_MC 6'd62
`define ADCC_CMP_MC 6'd8
`define ADCC_TRIAL_MC 3'd6
`define ADCC_SAR_CLR 10'h000
`define ADCC_SAR_TOP 10'h200
`define ADCC_TOP_IDX 4'h9
`define ADCC_NO_IDX 4'hF
// Controller register offsets (byte addresses)
`define ADCC_CMD_OFS 5'h00
`define ADCC_STAT_OFS 5'h04
`define ADCC_RES_OFS 5'h08
`define ADCC_INTSEL_OFS 5'h0C
`define ADCC_PORT_OFS 5'h10
`define ADCC_INT_BIT 2
`define ADCC_PORT_RST 4'hF
`define ADCC_RESP_OK 2'b00
`define ADCC_RESP_ERR 2'b10
`endif

// ===== test_adc_comparator_control.sv
// Bench joining controller and device, driven over AXI4-Lite
`timescale 1ns/1ps
module test_adc_comparator_control;
  import adcc_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] s_awaddr_i = 5'h00;
  logic [4:0] s_araddr_i = 5'h00;
  logic [31:0] s_wdata_i = 32'h0;
  logic s_awvalid_i = 1'b0;
  logic s_wvalid_i = 1'b0;
  logic s_arvalid_i = 1'b0;
  logic int_ack_i = 1'b0;
  logic vref_below_vin_i = 1'b0;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o;
  logic [1:0] s_bresp_o, s_rresp_o, rs;
  logic [31:0] s_rdata_o, st;
  logic [3:0] port_latch_o, ain_sel_o;
  logic dac_on_o;
  logic [9:0] dac_code_o, vin = 10'h000;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  adcc_if ln ();
  adcc_device adcc_device_inst (.mclk_i, .sys_rst_i, .link(ln.dev),
    .dac_code_o, .dac_on_o, .ain_sel_o, .vref_below_vin_i);
  adcc_ctrl adcc_ctrl_inst (.mclk_i, .sys_rst_i, .s_awaddr_i, .s_awvalid_i,
    .s_awready_o, .s_wdata_i, .s_wstrb_i(4'hF), .s_wvalid_i, .s_wready_o,
    .s_bresp_o, .s_bvalid_o, .s_bready_i(1'b1), .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i(1'b1),
    .int_ack_i, .irq_o, .port_latch_o, .link(ln.ctl));
  adcc_properties adcc_properties_inst (.mclk_i, .sys_rst_i,
    .instr_op(ln.instr_op), .instr_valid(ln.instr_valid), .acc_a(ln.acc_a),
    .acc_b(ln.acc_b), .int_en(ln.int_en), .int_taken(ln.int_taken),
    .rsp_valid(ln.rsp_valid), .rsp_a(ln.rsp_a), .rsp_b(ln.rsp_b),
    .skip(ln.skip), .flag(ln.flag), .busy(ln.busy));
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Analog stand-in: input sits above the DAC level while code < vin;
  // the cycle count cuts a hang short
  always @(posedge mclk_i) begin
    vref_below_vin_i <= dac_code_o < vin;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  // Ideal successive approximation: largest code below the input
  function automatic logic [9:0] sar_exp(input logic [9:0] v);
    return (v == 10'h000) ? 10'h000 : v - 10'h001;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles: valid held until its own ready edge
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_awready_o)
        s_awvalid_i <= 1'b0;
      if (s_wready_o)
        s_wvalid_i <= 1'b0;
    end while (!s_bvalid_o);
  endtask
  task automatic axr(input logic [4:0] a);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_arready_o)
        s_arvalid_i <= 1'b0;
    end while (!s_rvalid_o);
    st = s_rdata_o;
    rs = s_rresp_o;
  endtask
  // Commands are refused while busy, so wait for both busy bits
  task automatic cmd(input logic [3:0] op, input logic [3:0] a,
      input logic [3:0] b);
    axw(5'h00, {20'h0, b, a, op});
    do
      axr(5'h04);
    while (st[11] || st[10]);
    axr(5'h04);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    logic [1:0] sel;
    logic [7:0] cmp;
    logic [9:0] v;
    logic f;
    void'($urandom(65));
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    axr(5'h14);
    chk(32'(rs), 32'h2);
    axw(5'h10, 32'h0);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      v = (i < 2) ? {10{i[0]}} : 10'($urandom);
      vin <= v;
      sel = 2'($urandom);
      cmd(4'hF, {2'b00, sel}, 4'h0);
      axr(5'h08);
      chk(st, {22'h0, sar_exp(v)});
      chk(32'(dac_on_o), 32'h0);
      chk(32'(port_latch_o), 32'(ain_sel_o));
      chk(32'(ain_sel_o), 32'(4'h1 << sel));
    end
    $display("conversion test done");
    for (int i = 0; i < 4; i++) begin
      v = i[0] ? 10'h000 : 10'($urandom);
      cmp = i[0] ? 8'hFF : 8'($urandom);
      f = !({cmp, 2'b00} < v);
      vin <= v;
      sel = 2'($urandom);
      cmd(4'h1, {2'b10, sel}, 4'h0);
      axw(5'h0C, {29'h0, i[1], 2'b00});
      cmd(4'h4, cmp[3:0], cmp[7:4]);
      cmd(4'h5, 4'h0, 4'h0);
      chk(32'(st[7:0]), 32'(cmp));
      cmd(4'h3, 4'h0, 4'h0);
      chk(32'(st[9]), 32'(f));
      chk(32'(dac_on_o), 32'h0);
      if (i[1]) begin
        chk(32'(irq_o), 32'(f));
        int_ack_i <= 1'b1;
        @(posedge mclk_i);
        int_ack_i <= 1'b0;
        cmd(4'h0, 4'h0, 4'h0);
        chk(32'(irq_o), 32'h0);
      end else begin
        cmd(4'h8, 4'h0, 4'h0);
        chk(32'(st[8]), 32'(f));
      end
      chk(32'(st[9]), 32'h0);
      cmd(4'h1, {2'b00, sel}, 4'h0);
      chk(32'(st[9]), 32'h0);
      axr(5'h0C);
      chk(st, 32'h0);
      cmd(4'h4, ~cmp[3:0], 4'h0);
      cmd(4'h5, 4'h6, 4'h9);
      chk(32'(st[7:0]), 32'h96);
      cmd(4'h1, {2'b10, sel}, 4'h0);
      cmd(4'h5, 4'h0, 4'h0);
      chk(32'(st[7:0]), 32'(cmp));
    end
    $display("comparator test done");
    end_of_test();
  end
endmodule
